// *** design/mac_gap_consts.vh ***
// Constants for the gap timer and PHY management request block.
// Assumes a 16-bit register port with 3-bit word addresses.
`ifndef MAC_GAP_CONSTS_VH
`define MAC_GAP_CONSTS_VH

// Register offsets (word addresses)
`define OFS_CFG 3'h0
`define OFS_B2B 3'h1
`define OFS_SPLIT 3'h2
`define OFS_REQ 3'h3
`define OFS_ADDR 3'h4
`define OFS_RDATA 3'h6
`define OFS_IND 3'h7

// Reset values
`define RST_B2B 16'h0018
`define RST_SPLIT_100 16'h1018
`define RST_SPLIT_10 16'h4060
`define RST_REQ 16'h0000
`define RST_ADDR 16'h061F

// Field positions
`define B2B_LSB 0
`define TOTAL_LSB 0
`define DEFER_LSB 8
`define MODE_LSB 8
`define REQ_SINGLE 0
`define REQ_SCAN 1
`define PHY_REG_ADDR_FIELD_LSB 0
`define PHY_ADDR_FIELD_LSB 8
`define IND_BUSY 0
`define IND_SCAN 1
`define IND_VALID 2

// Interface modes
`define MODE_MII 2'b00
`define MODE_TPPMD 2'b01
`define MODE_10BT 2'b10

// Management clock timing
`define MCLK_NS 40
`define MDC_HALF_NS 200
`define MDC_HALF_CYC ((`MDC_HALF_NS + `MCLK_NS - 1) / `MCLK_NS)
`define FRAME_BITS 64
`define DRIVE_BITS 46
`define DATA_FIRST 48

`endif

// *** design/gap_timer.v ***
// Interpacket gap timer, counted in transmit clock ticks.
// Assumes tick_i is a one-cycle pulse per rising transmit clock edge.
`timescale 1ns/10ps
`default_nettype none
`include "mac_gap_consts.vh"

module gap_timer (
  input wire mclk_i,
  input wire rst_n_i,
  input wire tick_i,
  input wire tx_end_i,
  input wire b2b_i,
  input wire crs_i,
  input wire [6:0] b2b_gap_count_i,
  input wire [6:0] defer_window_count_i,
  input wire [6:0] total_gap_count_i,
  output wire gap_open_o
);

  // ----------------------------------------
  // States
  // ----------------------------------------
  localparam ST_OPEN = 2'd0; // Gap elapsed
  localparam ST_B2B = 2'd1; // Back-to-back gap
  localparam ST_SPLIT = 2'd2; // Deferring gap

  reg [1:0] state_reg; // Current state
  reg [6:0] cnt_reg; // Elapsed ticks
  reg open_reg; // Gap elapsed flag

  assign gap_open_o = open_reg;

  // ----------------------------------------
  // Gap sequencing
  // ----------------------------------------
  // Counter saturates below 128, limits are 7 bits
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg <= ST_OPEN;
      cnt_reg <= 7'h00;
      open_reg <= 1'b1;
    end else if (tx_end_i) begin
      // New gap after each frame
      cnt_reg <= 7'h00;
      open_reg <= 1'b0;
      state_reg <= b2b_i ? ST_B2B : ST_SPLIT;
    end else begin
      case (state_reg)
        ST_B2B: begin
          if (cnt_reg >= b2b_gap_count_i) begin // R01
            open_reg <= 1'b1;
            state_reg <= ST_OPEN;
          end else if (tick_i) begin
            cnt_reg <= cnt_reg + 7'h01;
          end
        end
        ST_SPLIT: begin
          if (crs_i && cnt_reg < defer_window_count_i) begin // R04 R06
            // Carrier in first part restarts the gap
            cnt_reg <= 7'h00;
          end else if (cnt_reg >= total_gap_count_i) begin // R05
            // Carrier ignored from here on
            open_reg <= 1'b1;
            state_reg <= ST_OPEN;
          end else if (tick_i) begin
            cnt_reg <= cnt_reg + 7'h01;
          end
        end
        ST_OPEN: begin
          open_reg <= 1'b1;
        end
        default: begin
          state_reg <= ST_OPEN;
        end
      endcase
    end
  end

endmodule // gap_timer
`default_nettype wire

// *** design/mac_gap_mgmt.v ***
// What this block does
// R01: Back-to-back gap equals field times tx clock
// R02: Back-to-back gap resets to 24 counts
// R03: Split gap reset value follows interface mode
// R04: Defer to carrier only in first part
// R05: Total gap equals low field count
// R06: Deferring part equals high field count
// R07: Host writes gaps only while idle
// R08: Host sets 96 counts for 10BASE-T
// R09: Request register write-only, zero reset, MII only
// R10: Single read bit self-clears on completion
// R11: Scan bit repeats reads until cleared
// R12: Host keeps scan set for link detect
// R13: Two-bit mode selects MII, TP-PMD, 10BASE-T
// R14: Reads use PHY and register address fields
// R15: Read result lands in read data register
// R16: Reserved gap bits read zero, ignore writes
// R17: Gap counts follow transmit clock safely
//
// Top of the gap timer and management read block.
// Assumes a plain register port and a PHY with MDC/MDIO.
`timescale 1ns/10ps
`default_nettype none
`include "mac_gap_consts.vh"

module mac_gap_mgmt (
  input wire mclk_i,
  input wire rst_n_i,
  input wire [2:0] addr_i,
  input wire [15:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output wire [15:0] rdata_o,
  input wire txclk_i,
  input wire crs_i,
  input wire tx_end_i,
  input wire b2b_i,
  input wire [1:0] mode_strap_i,
  input wire mdio_i,
  output wire mdio_o,
  output wire mdio_oe_o,
  output wire mdc_o,
  output wire gap_open_o
);

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  reg [1:0] rst_sync_reg; // Reset synchroniser
  wire rst_n; // Synchronised reset

  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_reg[1];

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  // Order: txclk, crs, mdio, strap[1:0]
  reg [4:0] meta_reg; // First stage, read by second only
  reg [4:0] sync_reg; // Second stage
  reg txclk_d_reg; // Delayed tx clock for edge find

  always @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= 5'h00;
      sync_reg <= 5'h00;
      txclk_d_reg <= 1'b0;
    end else begin
      meta_reg <= {txclk_i, crs_i, mdio_i, mode_strap_i};
      sync_reg <= meta_reg;
      txclk_d_reg <= sync_reg[4];
    end
  end

  // Tx clock is sampled, so rising edges map to ticks here
  wire tx_tick = sync_reg[4] & ~txclk_d_reg; // R17
  wire crs_s = sync_reg[3];
  wire mdio_s = sync_reg[2];
  wire [1:0] strap_s = sync_reg[1:0];

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [1:0] mode_reg; // Interface mode
  reg [6:0] b2b_gap_count; // Back-to-back gap
  reg [6:0] defer_window_count; // Deferring part
  reg [6:0] total_gap_count; // Total split gap
  reg single_read_request; // Single read pending
  reg scan_reg; // Continuous read
  reg [4:0] phy_addr_field; // PHY address
  reg [4:0] phy_reg_addr_field; // PHY register
  reg [15:0] phy_read_result; // Last read data
  reg valid_reg; // Result valid
  reg [2:0] init_reg; // Strap capture delay
  reg [15:0] rdata_reg; // Read data register
  reg busy_reg; // Frame in progress
  reg frame_done; // Pulse at frame end

  wire mii_mode = (mode_reg == `MODE_MII); // R13
  wire wr_req = wr_i && addr_i == `OFS_REQ;

  // Strap needs two cycles through sync before capture
  wire init_load = (init_reg == 3'd2);

  // Reset words at full width, sliced into fields below
  localparam [15:0] RST_B2B_W = `RST_B2B;
  localparam [15:0] RST_SPLIT_100_W = `RST_SPLIT_100;
  localparam [15:0] RST_SPLIT_10_W = `RST_SPLIT_10;
  localparam [15:0] RST_ADDR_W = `RST_ADDR;

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  always @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= `MODE_MII;
      b2b_gap_count <= RST_B2B_W[`B2B_LSB +: 7]; // R02
      defer_window_count <= RST_SPLIT_100_W[`DEFER_LSB +: 7];
      total_gap_count <= RST_SPLIT_100_W[`TOTAL_LSB +: 7];
      phy_addr_field <= RST_ADDR_W[`PHY_ADDR_FIELD_LSB +: 5];
      phy_reg_addr_field <= RST_ADDR_W[`PHY_REG_ADDR_FIELD_LSB +: 5];
      init_reg <= 3'd0;
    end else begin
      if (init_reg != 3'd3) begin
        init_reg <= init_reg + 3'd1;
      end
      if (init_load) begin
        // Catch strap after release
        mode_reg <= strap_s; // R13
        if (strap_s == `MODE_10BT) begin // R03
          defer_window_count <= RST_SPLIT_10_W[`DEFER_LSB +: 7];
          total_gap_count <= RST_SPLIT_10_W[`TOTAL_LSB +: 7];
        end
      end else if (wr_i) begin
        case (addr_i)
          `OFS_CFG: mode_reg <= wdata_i[`MODE_LSB +: 2];
          `OFS_B2B: b2b_gap_count <= wdata_i[`B2B_LSB +: 7]; // R16
          `OFS_SPLIT: begin // R16
            defer_window_count <= wdata_i[`DEFER_LSB +: 7];
            total_gap_count <= wdata_i[`TOTAL_LSB +: 7];
          end
          `OFS_ADDR: begin
            phy_addr_field <= wdata_i[`PHY_ADDR_FIELD_LSB +: 5];
            phy_reg_addr_field <= wdata_i[`PHY_REG_ADDR_FIELD_LSB +: 5];
          end
          default: begin
            // Other offsets hold nothing writable here
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Request bits
  // ----------------------------------------
  // Write wins over hardware clear at frame end
  always @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      single_read_request <= 1'b0; // R09
      scan_reg <= 1'b0;
    end else if (wr_req) begin
      single_read_request <= wdata_i[`REQ_SINGLE]; // R10
      scan_reg <= wdata_i[`REQ_SCAN]; // R11
    end else if (frame_done) begin
      single_read_request <= 1'b0; // R10
    end
  end

  // ----------------------------------------
  // Register reads
  // ----------------------------------------
  // Data stands only in the cycle after the strobe
  always @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= 16'h0000;
    end else if (!rd_i) begin
      rdata_reg <= 16'h0000;
    end else begin
      case (addr_i)
        `OFS_CFG: rdata_reg <= {6'h00, mode_reg, 8'h00};
        `OFS_B2B: rdata_reg <= {9'h000, b2b_gap_count}; // R16
        `OFS_SPLIT: rdata_reg <= {1'b0, defer_window_count, 1'b0,
                                  total_gap_count}; // R16
        `OFS_ADDR: rdata_reg <= {3'h0, phy_addr_field, 3'h0,
                                 phy_reg_addr_field};
        `OFS_RDATA: rdata_reg <= phy_read_result; // R15
        `OFS_IND: rdata_reg <= {13'h0000, valid_reg, scan_reg, busy_reg};
        default: rdata_reg <= 16'h0000; // Write-only and unmapped R09
      endcase
    end
  end

  assign rdata_o = rdata_reg;

  // ----------------------------------------
  // Management clock divider
  // ----------------------------------------
  reg [3:0] div_reg; // Half period counter
  reg mdc_reg; // Management clock
  wire mdc_tick = (div_reg == `MDC_HALF_CYC - 1);

  always @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      div_reg <= 4'h0;
      mdc_reg <= 1'b0;
    end else if (!busy_reg) begin
      // Clock parks low between frames
      div_reg <= 4'h0;
      mdc_reg <= 1'b0;
    end else if (mdc_tick) begin
      div_reg <= 4'h0;
      mdc_reg <= ~mdc_reg;
    end else begin
      div_reg <= div_reg + 4'h1;
    end
  end

  assign mdc_o = mdc_reg;

  // ----------------------------------------
  // Management read frame
  // ----------------------------------------
  // Preamble, start 01, read 10, addresses, turnaround, data
  reg [45:0] shift_reg; // Outgoing header bits
  reg [15:0] cap_reg; // Incoming data bits
  reg [5:0] bit_reg; // Bit position in frame
  reg mdio_out_reg; // Driven level
  reg mdio_oe_reg; // Drive enable

  // Only MII mode starts frames; none in the cycle after a frame ends,
  // while the single bit is still being cleared, or it would read twice
  wire start = !busy_reg && !frame_done && mii_mode
               && (single_read_request || scan_reg); // R09 R11
  wire rise = mdc_tick && !mdc_reg; // Sample point
  wire fall = mdc_tick && mdc_reg; // Drive point

  always @(posedge mclk_i or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg <= 46'h0;
      cap_reg <= 16'h0000;
      bit_reg <= 6'd0;
      mdio_out_reg <= 1'b0;
      mdio_oe_reg <= 1'b0;
      busy_reg <= 1'b0;
      frame_done <= 1'b0;
      phy_read_result <= 16'h0000;
      valid_reg <= 1'b0;
    end else begin
      frame_done <= 1'b0;
      if (start) begin
        // Load header from the address register
        shift_reg <= {32'hFFFF_FFFF, 2'b01, 2'b10,
                      phy_addr_field, phy_reg_addr_field}; // R14
        mdio_out_reg <= 1'b1;
        mdio_oe_reg <= 1'b1;
        bit_reg <= 6'd0;
        busy_reg <= 1'b1;
      end else if (busy_reg && rise) begin
        if (bit_reg >= `DATA_FIRST) begin
          cap_reg <= {cap_reg[14:0], mdio_s};
        end
      end else if (busy_reg && fall) begin
        if (bit_reg == `FRAME_BITS - 1) begin
          // Frame over, publish data
          busy_reg <= 1'b0;
          frame_done <= 1'b1;
          phy_read_result <= cap_reg; // R15
          valid_reg <= 1'b1;
        end else begin
          bit_reg <= bit_reg + 6'd1;
          shift_reg <= {shift_reg[44:0], 1'b0};
          mdio_out_reg <= shift_reg[44];
          // Release line at turnaround
          mdio_oe_reg <= (bit_reg < `DRIVE_BITS - 1);
        end
      end
    end
  end

  assign mdio_o = mdio_out_reg;
  assign mdio_oe_o = mdio_oe_reg;

  // ----------------------------------------
  // Gap timer
  // ----------------------------------------
  // Host must not rewrite gaps mid-transmit
  gap_timer u_gap (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n),
    .tick_i(tx_tick), // R17
    .tx_end_i(tx_end_i),
    .b2b_i(b2b_i),
    .crs_i(crs_s),
    .b2b_gap_count_i(b2b_gap_count), // R01 R07
    .defer_window_count_i(defer_window_count), // R06
    .total_gap_count_i(total_gap_count), // R05
    .gap_open_o(gap_open_o)
  );

endmodule // mac_gap_mgmt
`default_nettype wire

// *** verification/phy_mgmt_model.sv ***
// Behavioural PHY on the management link.
// Assumes MDC low between frames and a pull-up on the data line.
`timescale 1ns/10ps
`default_nettype none
module phy_mgmt_model (
  input wire logic rst_n_i,
  input wire logic mdc_i,
  input wire logic mac_data_i,
  input wire logic mac_oe_i,
  output wire logic line_o,
  output var logic [7:0] frames_o
);
  logic busy = 1'b0; // Frame in progress
  logic drv = 1'b0; // PHY drives the line
  logic bitv = 1'b0; // Bit the PHY drives
  logic [9:0] addr_sh = 10'h000; // Last ten bits sampled
  logic [15:0] val = 16'h0000; // Answer word
  int n = 0; // Bits sampled so far
  // Released line floats up, never a stale value
  assign line_o = mac_oe_i ? mac_data_i : (drv ? bitv : 1'b1);
  // Sample at MDC rise; answer encodes both addresses
  always @(posedge mdc_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy = 1'b0;
      n = 0;
      frames_o = 8'h00;
    end else if (busy || mac_oe_i) begin
      busy = 1'b1;
      addr_sh = {addr_sh[8:0], line_o};
      n++;
      if (n == 46) val = {3'b101, addr_sh, 3'b011};
      if (n == 64) begin
        busy = 1'b0;
        n = 0;
        frames_o++;
      end
    end
  end
  // Turnaround zero, then data MSB first
  always @(negedge mdc_i) begin
    drv = busy && n >= 47;
    bitv = (n >= 48) ? val[63 - n] : 1'b0;
  end
endmodule // phy_mgmt_model
`default_nettype wire

// *** verification/mac_gap_mgmt_asserts.sv ***
// Port checker for the gap timer and management block.
// Assumes it is bound onto mac_gap_mgmt.
`timescale 1ns/10ps
`default_nettype none
module mac_gap_mgmt_asserts (
  input wire logic mclk_i,
  input wire logic rst_n_i,
  input wire logic [2:0] addr_i,
  input wire logic rd_i,
  input wire logic [15:0] rdata_o,
  input wire logic tx_end_i,
  input wire logic gap_open_o,
  input wire logic mdio_o,
  input wire logic mdio_oe_o,
  input wire logic mdc_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  // MDC half periods are five system clocks
  sequence mdc_hi_s; mdc_o [*5] ##1 !mdc_o; endsequence
  sequence mdc_lo_s; !mdc_o [*5]; endsequence
  AST_RDATA_IDLE: assert property (!rd_i |=> rdata_o == 16'h0000)
    else $error("read data not idle");
  AST_REQ_WO: assert property (rd_i && addr_i == 3'h3 |=> rdata_o == 16'h0000)
    else $error("request register readable");
  AST_GAP_FALL: assert property (tx_end_i |=> !gap_open_o)
    else $error("gap not restarted");
  AST_GAP_HOLD: assert property (gap_open_o && !tx_end_i |=> gap_open_o)
    else $error("gap closed by itself");
  AST_MDC_HIGH: assert property ($rose(mdc_o) |-> mdc_hi_s)
    else $error("mdc high phase wrong");
  AST_MDC_LOW: assert property ($fell(mdc_o) |-> mdc_lo_s)
    else $error("mdc low phase wrong");
  AST_OE_START: assert property ($rose(mdio_oe_o) |-> mdio_o && !mdc_o)
    else $error("frame start wrong");
  AST_OE_EDGE: assert property ($changed(mdio_oe_o) |-> !mdc_o)
    else $error("drive enable moved while mdc high");
  AST_MDIO_STABLE: assert property (mdc_o |-> $stable(mdio_o))
    else $error("mdio moved while mdc high");
endmodule // mac_gap_mgmt_asserts
bind mac_gap_mgmt mac_gap_mgmt_asserts u_chk (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
  .rd_i(rd_i), .rdata_o(rdata_o), .tx_end_i(tx_end_i), .gap_open_o(gap_open_o), .mdio_o(mdio_o),
  .mdio_oe_o(mdio_oe_o), .mdc_o(mdc_o));
`default_nettype wire

// *** verification/testbench.sv ***
// Self-checking bench for mac_gap_mgmt.
// Assumes the PHY model and checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic mclk_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0, txclk_i = 1'b0;
  logic crs_i = 1'b0, tx_end_i = 1'b0, b2b_i = 1'b0;
  logic [2:0] addr_i = 3'h0;
  logic [15:0] wdata_i = 16'h0000;
  logic [1:0] mode_strap_i = 2'b00;
  wire logic [15:0] rdata_o;
  wire logic mdio_i, mdio_o, mdio_oe_o, mdc_o, gap_open_o;
  wire logic [7:0] frames;
  int n_fail = 0, n_compared = 0, cyc = 0;
  logic [15:0] v;
  logic [7:0] f;
  mac_gap_mgmt u_dut (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .txclk_i(txclk_i), .crs_i(crs_i),
    .tx_end_i(tx_end_i), .b2b_i(b2b_i), .mode_strap_i(mode_strap_i), .mdio_i(mdio_i),
    .mdio_o(mdio_o), .mdio_oe_o(mdio_oe_o), .mdc_o(mdc_o), .gap_open_o(gap_open_o));
  phy_mgmt_model u_phy (.rst_n_i(rst_n_i), .mdc_i(mdc_o), .mac_data_i(mdio_o),
    .mac_oe_i(mdio_oe_o), .line_o(mdio_i), .frames_o(frames));
  // 25 MHz system clock, 320 ns transmit clock off phase
  initial forever #20 mclk_i = ~mclk_i;
  initial begin
    #7;
    forever #160 txclk_i = ~txclk_i;
  end
  // Hang guard
  always @(posedge mclk_i) begin
    cyc++;
    if (cyc == 60000) begin
      n_fail++;
      final_report;
    end
  end
  task automatic final_report;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge mclk_i);
    wr_i <= 1'b1;
    addr_i <= a;
    wdata_i <= d;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask
  // Data stand only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [15:0] d);
    @(posedge mclk_i);
    rd_i <= 1'b1;
    addr_i <= a;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 d = rdata_o;
  endtask
  task automatic rchk(input logic [2:0] a, input logic [15:0] exp);
    rd(a, v);
    chk(v, exp);
  endtask
  // Six clocks past a transmit edge: clear of sync races
  task automatic align;
    @(posedge txclk_i);
    repeat (6) @(posedge mclk_i);
  endtask
  task automatic t_regs;
    rchk(3'h1, 16'h0018);
    rchk(3'h2, 16'h1018);
    rchk(3'h3, 16'h0000);
    rchk(3'h4, 16'h061F);
    rchk(3'h5, 16'h0000);
    wr(3'h1, 16'hFFFF);
    rchk(3'h1, 16'h007F);
    wr(3'h2, 16'hFFFF);
    rchk(3'h2, 16'h7F7F);
  endtask
  // Count transmit ticks from gap start until it opens
  task automatic gap(input logic b, input logic [2:0] a, input logic [15:0] d, input int con,
                     input int coff, input int n);
    int i;
    i = 0;
    wr(a, d);
    align;
    tx_end_i <= 1'b1;
    b2b_i <= b;
    @(posedge mclk_i);
    tx_end_i <= 1'b0;
    do begin
      align;
      i++;
      crs_i <= (i >= con && i < coff);
      #1;
    end while (!gap_open_o && i < 200);
    chk(16'(i), 16'(n));
  endtask
  task automatic t_read;
    f = frames;
    wr(3'h4, 16'h0A15);
    wr(3'h3, 16'h0001);
    rd(3'h7, v);
    chk(16'(v[0]), 16'h0001);
    do rd(3'h7, v); while (v[0] !== 1'b0 && cyc < 50000);
    chk(16'(v[2]), 16'h0001);
    rchk(3'h6, {3'b101, 5'h0A, 5'h15, 3'b011});
    chk(16'(frames), 16'(f + 8'h01));
  endtask
  task automatic t_scan;
    f = frames;
    wr(3'h3, 16'h0002);
    repeat (1400) @(posedge mclk_i);
    rd(3'h7, v);
    chk(16'(v[1]), 16'h0001);
    chk(16'(frames - f >= 8'h02), 16'h0001);
    wr(3'h3, 16'h0000);
    repeat (700) @(posedge mclk_i);
    f = frames;
    repeat (700) @(posedge mclk_i);
    chk(16'(frames), 16'(f));
  endtask
  // Other modes: request must start nothing
  task automatic t_mode;
    for (int m = 1; m < 3; m++) begin
      wr(3'h0, {6'h00, 2'(m), 8'h00});
      rchk(3'h0, {6'h00, 2'(m), 8'h00});
      f = frames;
      wr(3'h3, 16'h0001);
      repeat (700) @(posedge mclk_i);
      chk(16'(frames), 16'(f));
      wr(3'h3, 16'h0000);
    end
    wr(3'h0, 16'h0000);
  endtask
  task automatic t_strap;
    rst_n_i <= 1'b0;
    mode_strap_i <= 2'b10;
    repeat (8) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    repeat (8) @(posedge mclk_i);
    rchk(3'h2, 16'h4060);
    rchk(3'h1, 16'h0018);
    wr(3'h1, 16'h0060);
    rchk(3'h1, 16'h0060);
  endtask
  initial begin
    repeat (8) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    repeat (8) @(posedge mclk_i);
    t_regs;
    gap(1'b1, 3'h1, 16'h0005, 0, 0, 5);
    gap(1'b0, 3'h2, 16'h040A, 1, 3, 13);
    gap(1'b0, 3'h2, 16'h040A, 5, 7, 10);
    t_read;
    t_scan;
    t_mode;
    t_strap;
    final_report;
  end
endmodule // testbench
`default_nettype wire
